// ### verilog/media_port_regs.sv
// Media select, general purpose pins and printer port registers on AXI4-Lite.
// Assumes pins are asynchronous; status pins are sampled through pin_sync, data lines through their own two-flop stage.
//
// Overview of operation
// - Input status bits 6..4 show general inputs 2, 1, 0.
// - Input status bit 2 shows internal PHY speed, one for 100Mbps.
// - Input status bit 1 shows internal PHY duplex, one for full.
// - Input status bit 0 shows internal PHY link, one when up.
// - Control bit 6 powers down internal PHY and MAC; reset zero.
// - With priority bit set, media bit picks internal (0) or external (1).
// - Control bit 0 drives general output 0 inverted; resets zero.
// - Printer data resets as input; drives lines only while enable is zero.
// - Printer status bit 7 reads the inverted busy pin.
// - Printer status bit 6 reads the acknowledge pin unchanged.
// - Status bits 5..3 read paper-out, selected and error pins unchanged.
// - Command bit 5 is active-low data drive enable, resetting to one.
// - Command bit 4 stores interrupt enable but raises no printer interrupt.
// - Command bit 3 selects printer; select-in pin carries it inverted.
// - Command bit 2 is active-low initialise; pin carries it unchanged.
// - Command bit 1 requests auto feed; pin carries it inverted.
// - Software pulses command bit 0 low-high-low; strobe pin is inverted.
`timescale 1ns/1ps
`default_nettype none
module media_port_regs
  import media_port_pkg::*;
(
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // General inputs and internal PHY status.
  input  wire logic [2:0]        general_input,
  input  wire logic              internal_phy_speed_flag,
  input  wire logic              internal_phy_duplex_flag,
  input  wire logic              internal_phy_link,
  // Media and power control.
  output logic                   phy_powerdown_control,
  output logic                   external_media_selected,
  output logic                   general_output_0_n,
  // Printer data lines: input and output per pin, one shared active-low enable.
  input  wire logic [7:0]        printer_byte_lines_in,
  output logic [7:0]             printer_byte_lines_out,
  output logic                   printer_byte_lines_oe_n,
  // Printer status pins.
  input  wire logic              printer_busy,
  input  wire logic              printer_ack_n,
  input  wire logic              printer_no_media,
  input  wire logic              printer_online,
  input  wire logic              printer_error_n,
  // Printer control pins.
  output logic                   printer_choose_pin_n,
  output logic                   printer_init_pin_n,
  output logic                   printer_autofeed_pin_n,
  output logic                   printer_latch_pin_n,
  // Interrupt.
  output logic                   irq
);
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_idx;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_printer_latch_pin_n;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  ctrl;
    logic [7:0]  pdata;
    logic [7:0]  pcmd;
    logic [3:0]  irq_status;
    logic [3:0]  irq_enable;
    logic [3:0]  prev_ev;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;
  pin_sync_if  pins ();
  logic [7:0]  gi_view;
  logic [7:0]  ps_view;
  logic [3:0]  ev_now;
  logic        wr_fire;
  logic [7:0]  data_meta_reg;
  logic [7:0]  pins_data_sync;

  // Word index from a byte address; the low two bits are dropped.
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // Whether an index names a mapped register for the given direction.
  function automatic logic mapped(input logic [7:0] i, input logic is_wr);
    case (i)
      IDX_INPUT_OUTPUT, IDX_PRN_DATA, IDX_PRN_COMMAND, IDX_IRQ_ENABLE: return 1'b1;
      IDX_PRN_STATUS, IDX_IRQ_STATUS: return !is_wr;
      IDX_IRQ_CLEAR: return is_wr;
      default: return 1'b0;
    endcase
  endfunction

  // Pin bundle into the synchroniser.
  assign pins.raw = {general_input, internal_phy_speed_flag, internal_phy_duplex_flag,
                     internal_phy_link, printer_busy, printer_ack_n, printer_no_media,
                     printer_online, printer_error_n};

  pin_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (pins)
  );

  // Read views of the pin-driven registers.
  always_comb begin
    gi_view           = 8'h00;
    gi_view[GI_IN2]   = pins.synced[10];
    gi_view[GI_IN1]   = pins.synced[9];
    gi_view[GI_IN0]   = pins.synced[8];
    gi_view[GI_SPEED] = pins.synced[7];
    gi_view[GI_DUPLX] = pins.synced[6];
    gi_view[GI_LINK]  = pins.synced[5];
    ps_view            = 8'h00;
    ps_view[PS_BUSY_N] = !pins.synced[4];
    ps_view[PS_ACK]    = pins.synced[3];
    ps_view[PS_NOMED]  = pins.synced[2];
    ps_view[PS_ONLINE] = pins.synced[1];
    ps_view[PS_ERR]    = pins.synced[0];
  end

  // Events: link lost, acknowledge fell, error fell, paper ran out.
  assign ev_now  = {pins.synced[2], !pins.synced[0], !pins.synced[3], !pins.synced[5]};
  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;

  // Bus handshakes, register writes, reads and interrupt status.
  always_comb begin
    logic [3:0] rise;
    logic [7:0] ri;
    logic [7:0] wb;
    rise       = '0;
    ri         = '0;
    wb         = '0;
    state_next = state_reg;
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx  = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_printer_latch_pin_n = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = mapped(state_reg.aw_idx, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      wb = state_reg.w_data[7:0];
      if (state_reg.w_printer_latch_pin_n[0]) begin
        unique case (state_reg.aw_idx)
          IDX_INPUT_OUTPUT: state_next.ctrl = wb & 8'h71;
          IDX_PRN_DATA:     state_next.pdata = wb;
          IDX_PRN_COMMAND:  state_next.pcmd = wb & 8'h3f;
          IDX_IRQ_ENABLE:   state_next.irq_enable = wb[3:0];
          default: ;
        endcase
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_reg.rvalid) begin
      ri = word_idx(s_axi_araddr);
      state_next.rvalid = 1'b1;
      state_next.rresp  = mapped(ri, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      unique case (ri)
        IDX_INPUT_OUTPUT: state_next.rdata = {24'h00_0000, gi_view};
        IDX_PRN_DATA:     state_next.rdata = {24'h00_0000, state_reg.pcmd[PC_DRV_N] ?
                                              pins_data_sync : state_reg.pdata};
        IDX_PRN_STATUS:   state_next.rdata = {24'h00_0000, ps_view};
        IDX_PRN_COMMAND:  state_next.rdata = {24'h00_0000, state_reg.pcmd};
        IDX_IRQ_STATUS:   state_next.rdata = {28'h000_0000, state_reg.irq_status};
        IDX_IRQ_ENABLE:   state_next.rdata = {28'h000_0000, state_reg.irq_enable};
        default:          state_next.rdata = 32'h0000_0000;
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // Sticky events; a new event wins over a same-cycle clear.
    rise = ev_now & ~state_reg.prev_ev;
    state_next.prev_ev = ev_now;
    if (wr_fire && state_reg.aw_idx == IDX_IRQ_CLEAR && state_reg.w_printer_latch_pin_n[0]) begin
      state_next.irq_status = state_reg.irq_status & ~state_reg.w_data[3:0];
    end
    state_next.irq_status = state_next.irq_status | rise;
  end

  // Printer data lines sampled through their own two-flop stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_meta_reg  <= 8'h00;
      pins_data_sync <= 8'h00;
    end else begin
      data_meta_reg  <= printer_byte_lines_in;
      pins_data_sync <= data_meta_reg;
    end
  end

  // Registers the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= '0;
      state_reg.ctrl       <= OC_RESET;
      state_reg.pdata      <= PD_RESET;
      state_reg.pcmd       <= PC_RESET;
      state_reg.irq_status <= IRQ_RESET;
      state_reg.irq_enable <= IRQ_RESET;
      state_reg.prev_ev    <= 4'hf;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus outputs.
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready  = !state_reg.w_held;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rresp   = state_reg.rresp;
  assign s_axi_rdata   = state_reg.rdata;

  // Media choice from the control register when priority is set, else from link and general input 0; power control from the register.
  assign phy_powerdown_control = state_reg.ctrl[OC_PWRDN];
  assign external_media_selected = state_reg.ctrl[OC_PRIO] ? state_reg.ctrl[OC_MEDIA]
                                   : (!pins.synced[5] && !pins.synced[8]);
  assign general_output_0_n = !state_reg.ctrl[OC_GENERAL_OUTPUT_0_N];

  // Printer pins; the interrupt enable bit feeds only the command register read-back.
  assign printer_byte_lines_out  = state_reg.pdata;
  assign printer_byte_lines_oe_n = state_reg.pcmd[PC_DRV_N];
  assign printer_choose_pin_n    = !state_reg.pcmd[PC_CHOOSE];
  assign printer_init_pin_n      = state_reg.pcmd[PC_INIT_N];
  assign printer_autofeed_pin_n  = !state_reg.pcmd[PC_AFEED];
  assign printer_latch_pin_n     = !state_reg.pcmd[PC_LATCH];
  assign irq = |(state_reg.irq_status & state_reg.irq_enable);

  // Checks of the register bank behaviour.
  gpo_invert_a: assert property (@(posedge aclk) disable iff (!aresetn)
    general_output_0_n == !state_reg.ctrl[OC_GENERAL_OUTPUT_0_N]) else $error("gpo not inverted");
  pwrdn_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_INPUT_OUTPUT && state_reg.w_printer_latch_pin_n[0]
    |=> phy_powerdown_control == $past(state_reg.w_data[OC_PWRDN]))
    else $error("powerdown not written");
  media_prog_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.ctrl[OC_PRIO] |-> external_media_selected == state_reg.ctrl[OC_MEDIA])
    else $error("program media ignored");
  media_auto_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !state_reg.ctrl[OC_PRIO] && pins.synced[5] |-> !external_media_selected)
    else $error("link up must keep internal");
  drive_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_PRN_COMMAND
    |-> s_axi_rdata[PC_DRV_N] == printer_byte_lines_oe_n) else $error("enable mismatch");
  busy_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_PRN_STATUS
    |-> s_axi_rdata[PS_BUSY_N] == $past(!pins.synced[4])) else $error("busy not inverted");
  link_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_INPUT_OUTPUT
    |-> s_axi_rdata[GI_LINK] == $past(pins.synced[5])) else $error("link bit wrong");
  strobe_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.pcmd[PC_LATCH]) |-> !printer_latch_pin_n) else $error("strobe polarity");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> ##0 |(state_reg.irq_status & state_reg.irq_enable)) else $error("irq spurious");
  // Accepted command and control writes reach the select-in, initialise, autofeed, strobe and general output pins with the stated polarity.
  choose_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_PRN_COMMAND && state_reg.w_printer_latch_pin_n[0]
    |=> printer_choose_pin_n == !$past(state_reg.w_data[PC_CHOOSE]))
    else $error("select-in pin not inverted");
  init_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_PRN_COMMAND && state_reg.w_printer_latch_pin_n[0]
    |=> printer_init_pin_n == $past(state_reg.w_data[PC_INIT_N]))
    else $error("initialise pin polarity wrong");
  afeed_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_PRN_COMMAND && state_reg.w_printer_latch_pin_n[0]
    |=> printer_autofeed_pin_n == !$past(state_reg.w_data[PC_AFEED]))
    else $error("autofeed pin not inverted");
  latch_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_PRN_COMMAND && state_reg.w_printer_latch_pin_n[0]
    |=> printer_latch_pin_n == !$past(state_reg.w_data[PC_LATCH]))
    else $error("strobe pin not inverted");
  gpo_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && state_reg.aw_idx == IDX_INPUT_OUTPUT && state_reg.w_printer_latch_pin_n[0]
    |=> general_output_0_n == !$past(state_reg.w_data[OC_GENERAL_OUTPUT_0_N]))
    else $error("general output not inverted");
  // Read words carry the pin levels of the cycle in which the read was taken.
  gi_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_INPUT_OUTPUT
    |-> s_axi_rdata[7:0] == {1'b0, $past(pins.synced[10:8]), 1'b0, $past(pins.synced[7:5])})
    else $error("input status word wrong");
  status_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_PRN_STATUS
    |-> s_axi_rdata[6:0] == {$past(pins.synced[3:0]), 3'b000})
    else $error("printer status pins wrong");
  data_in_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg.rvalid) && $past(word_idx(s_axi_araddr)) == IDX_PRN_DATA
    && $past(state_reg.pcmd[PC_DRV_N]) |-> s_axi_rdata[7:0] == $past(pins_data_sync))
    else $error("input mode data wrong");
  irq_printer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(state_reg.pcmd[PC_PRINTER_INTERRUPT_ENABLE]) && $stable(state_reg.irq_status & state_reg.irq_enable)
    |-> $stable(irq))
    else $error("printer interrupt enable acted");
  refused_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !mapped(state_reg.aw_idx, 1'b1)
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("refused write not flagged");
  sticky_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_now[EV_NOMED] && !state_reg.prev_ev[EV_NOMED]
    |=> state_reg.irq_status[EV_NOMED])
    else $error("paper event not latched");
  strobe_cov: cover property (@(posedge aclk) $fell(printer_latch_pin_n));
  irq_cov: cover property (@(posedge aclk) $rose(irq));
  write_cov: cover property (@(posedge aclk) wr_fire ##1 s_axi_bvalid);
  read_cov: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  drive_cov: cover property (@(posedge aclk) $fell(printer_byte_lines_oe_n));
endmodule // media_port_regs
`default_nettype wire

// ### verilog/media_port_pkg.sv
// Package for the media select and printer port register bank.
// Assumes a single 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package media_port_pkg;

  // Register byte offsets; five of the printed offsets are not word aligned,
  // so each printed offset is kept as an index and the byte address is 4x.
  localparam logic [7:0] IDX_INPUT_OUTPUT = 8'h17;
  localparam logic [7:0] IDX_PRN_DATA     = 8'h18;
  localparam logic [7:0] IDX_PRN_STATUS   = 8'h19;
  localparam logic [7:0] IDX_PRN_COMMAND  = 8'h1a;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] IDX_IRQ_ENABLE   = 8'h21;
  localparam logic [7:0] IDX_IRQ_CLEAR    = 8'h22;
  localparam int         ADDR_W           = 10;

  // Field positions of the input status register.
  localparam int GI_IN2   = 6;
  localparam int GI_IN1   = 5;
  localparam int GI_IN0   = 4;
  localparam int GI_SPEED = 2;
  localparam int GI_DUPLX = 1;
  localparam int GI_LINK  = 0;

  // Field positions of the output and media control register.
  localparam int OC_PWRDN = 6;
  localparam int OC_MEDIA = 5;
  localparam int OC_PRIO  = 4;
  localparam int OC_GENERAL_OUTPUT_0_N  = 0;

  // Field positions of the printer status and command registers.
  localparam int PS_BUSY_N = 7;
  localparam int PS_ACK    = 6;
  localparam int PS_NOMED  = 5;
  localparam int PS_ONLINE = 4;
  localparam int PS_ERR    = 3;
  localparam int PC_DRV_N  = 5;
  localparam int PC_PRINTER_INTERRUPT_ENABLE  = 4;
  localparam int PC_CHOOSE = 3;
  localparam int PC_INIT_N = 2;
  localparam int PC_AFEED  = 1;
  localparam int PC_LATCH  = 0;

  // Reset values.
  localparam logic [7:0] OC_RESET  = 8'h00;
  localparam logic [7:0] PD_RESET  = 8'h00;
  localparam logic [7:0] PC_RESET  = 8'h24;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Interrupt event bits.
  localparam int EV_LINK = 0;
  localparam int EV_ACK  = 1;
  localparam int EV_ERR  = 2;
  localparam int EV_NOMED = 3;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/pin_sync_if.sv
// Interface carrying raw and synchronised status pins to the bank.
// Assumes all pins are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [10:0] raw;
  logic [10:0] synced;
  modport syncer (input raw, output synced);
  modport user (output raw, input synced);
endinterface
`default_nettype wire

// ### verilog/pin_sync.sv
// Two-flop synchroniser for the asynchronous status pins.
// Assumes one clock aclk with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import media_port_pkg::*;
(
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin bundle.
  pin_sync_if.syncer pins
);
  typedef struct packed {
    logic [10:0] meta;
    logic [10:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // The first stage only feeds the second stage.
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = pins.raw;
    state_next.stable = state_reg.meta;
  end

  // Registers the state, clearing it on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins.synced = state_reg.stable;
endmodule // pin_sync
`default_nettype wire

// ### sim/printer_model.sv
// Behavioural printer on the far side of the parallel port.
// Assumes aclk is the core clock and pins are sampled on its rising edge.
`timescale 1ns/1ps
`default_nettype none
module printer_model #(
  parameter int HOLD_CYCLES = 20
) (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Data lines from the port and the byte the printer drives back.
  input  wire logic [7:0] data_out,
  input  wire logic       oe_n,
  input  wire logic [7:0] reply_byte,
  output logic [7:0]      data_wire,
  // Handshake.
  input  wire logic       latch_pin_n,
  output logic            busy,
  output logic            ack_n,
  // What the printer took.
  output logic [7:0]      got_byte,
  output int              got_count
);
  logic latch_q;
  int   busy_cnt;

  // The wire carries the port's byte only while the port drives it.
  assign data_wire = oe_n ? reply_byte : data_out;

  // Takes the byte as the latch pulse starts, stays busy, then acks low.
  always @(posedge aclk) begin
    latch_q <= latch_pin_n;
    if (!aresetn) begin
      busy_cnt  <= 0;
      got_count <= 0;
      busy      <= 1'b0;
      ack_n     <= 1'b1;
    end else if (latch_q && !latch_pin_n && busy_cnt == 0) begin
      got_byte  <= data_wire;
      got_count <= got_count + 1;
      busy_cnt  <= HOLD_CYCLES;
      busy      <= 1'b1;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      ack_n    <= !(busy_cnt <= 3 && busy_cnt > 1);
      busy     <= busy_cnt > 1;
    end
  end
endmodule // printer_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the media select and printer port registers.
// Assumes the register bank answers on AXI4-Lite with byte address 4x index.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import media_port_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ext_sel, pwrdn, gpo_n, oe_n;
  logic busy, ack_n, paper, online, err_n, choose_n, init_n, afeed_n, latch_n, irq;
  logic spd, dpx, link;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  gin;
  logic [7:0]  dline_in, dline_out, reply, got, eb;
  int err_count, tests_run, cycles, got_n, seed, v;

  media_port_regs media_port_regs_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .general_input(gin), .internal_phy_speed_flag(spd), .internal_phy_duplex_flag(dpx),
    .internal_phy_link(link), .phy_powerdown_control(pwrdn),
    .external_media_selected(ext_sel), .general_output_0_n(gpo_n),
    .printer_byte_lines_in(dline_in), .printer_byte_lines_out(dline_out),
    .printer_byte_lines_oe_n(oe_n), .printer_busy(busy), .printer_ack_n(ack_n),
    .printer_no_media(paper), .printer_online(online), .printer_error_n(err_n),
    .printer_choose_pin_n(choose_n), .printer_init_pin_n(init_n),
    .printer_autofeed_pin_n(afeed_n), .printer_latch_pin_n(latch_n), .irq(irq));

  printer_model #(.HOLD_CYCLES(20)) printer_model_i (.aclk(aclk), .aresetn(aresetn),
    .data_out(dline_out), .oe_n(oe_n), .reply_byte(reply), .data_wire(dline_in),
    .latch_pin_n(latch_n), .busy(busy), .ack_n(ack_n), .got_byte(got), .got_count(got_n));

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      give_verdict();
    end
  end

  // Compares a read word or response against the model.
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask

  // Compares the packed output pins against the model.
  task automatic cmp_pins(input logic [7:0] e);
    tests_run++;
    if ({oe_n, choose_n, init_n, afeed_n, latch_n, gpo_n, pwrdn, irq} !== e) begin
      err_count++;
      $display("[FAIL] %0t pins want %b", $time, e);
    end
  endtask

  // One write; valids held until each channel's own handshake.
  task automatic axi_write(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0000_00, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask

  // One read; arvalid held until taken, rready until rvalid.
  task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask

  // Writes and expects OKAY.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    axi_write({idx, 2'b00}, d, rs);
    cmp_data({30'h0, rs}, {30'h0, RESP_OKAY}, "bresp");
  endtask

  // Reads and compares with the expected byte.
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e, input string m);
    axi_read({idx, 2'b00}, rd, rs);
    cmp_data(rd, {24'h0000_00, e}, m);
  endtask

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    wstrb = 4'hf;
    {gin, spd, dpx, link, paper, err_n, online} = 9'h003;
    {err_count, tests_run, cycles} = '0;
    seed = 32'hab32;
    reply = 8'h5a;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_pins(8'b1111_1100);
    rd_chk(IDX_PRN_COMMAND, 8'h24, "cmd reset");
    rd_chk(IDX_PRN_DATA, reply, "data input mode");
    // Media choice table with random status pins.
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      gin <= {v[1:0], i[0]};
      {spd, dpx, link} <= {v[2], v[3], i[1]};
      wr(IDX_INPUT_OUTPUT, {1'b0, i[0], i[2], i[3], 3'b000, i[1]});
      repeat (4) @(posedge aclk);
      tests_run++;
      if (ext_sel !== (i[3] ? i[2] : !i[1] && !i[0])) begin
        err_count++;
        $display("[FAIL] %0t media choice case %0d", $time, i);
      end
      cmp_pins({5'b11111, !i[1], i[0], 1'b0});
      eb = {1'b0, v[1:0], i[0], 1'b0, v[2], v[3], i[1]};
      rd_chk(IDX_INPUT_OUTPUT, eb, "in");
    end
    // Command register bits and their pins.
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr(IDX_PRN_COMMAND, v[7:0]);
      repeat (2) @(posedge aclk);
      cmp_pins({v[5], !v[3], v[2], !v[1], !v[0], 3'b010});
      rd_chk(IDX_PRN_COMMAND, v[7:0] & 8'h3f, "cmd");
    end
    // Stored byte, driven lines, and a latch pulse into the printer.
    wr(IDX_PRN_COMMAND, 8'h0c);
    repeat (25) @(posedge aclk);
    v = got_n;
    wr(IDX_PRN_DATA, 8'hc3);
    rd_chk(IDX_PRN_DATA, 8'hc3, "data out mode");
    wr(IDX_PRN_COMMAND, 8'h0d);
    wr(IDX_PRN_COMMAND, 8'h0c);
    rd_chk(IDX_PRN_STATUS, {2'b01, paper, 1'b1, err_n, 3'b000}, "busy");
    cmp_data({24'h0, got}, 32'h0000_00c3, "latched byte");
    cmp_data(got_n, v + 1, "latch count");
    repeat (25) @(posedge aclk);
    // Printer status pins with random levels.
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      {paper, online, err_n} <= v[2:0];
      repeat (4) @(posedge aclk);
      rd_chk(IDX_PRN_STATUS, {2'b11, v[2:0], 3'b000}, "status");
    end
    // Interrupt raise, mask and clear.
    paper <= 1'b0;
    wr(IDX_IRQ_CLEAR, 8'h0f);
    wr(IDX_IRQ_ENABLE, 8'h08);
    paper <= 1'b1;
    repeat (4) @(posedge aclk);
    cmp_data({31'h0, irq}, 32'h0000_0001, "irq raised");
    rd_chk(IDX_IRQ_STATUS, 8'h08, "irq status");
    wr(IDX_IRQ_ENABLE, 8'h00);
    cmp_data({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(IDX_IRQ_CLEAR, 8'h08);
    rd_chk(IDX_IRQ_STATUS, 8'h00, "irq cleared");
    // Refused accesses.
    axi_read(10'h3fc, rd, rs);
    cmp_data({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_write({IDX_PRN_STATUS, 2'b00}, 8'hff, rs);
    cmp_data({30'h0, rs}, {30'h0, RESP_SLVERR}, "read-only write");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
